// ### hw/vtsm_vector_map.v
// vector table, start-up signature evaluation and cause registers
// Overview of operation
// - words 0xff80 to 0xffff are reserved for vectors, signatures and passwords
// - after reset fetch start address from word 0xfffe and release the core there
// - handler vectors lie below the reset vector, from 0xfffd downward
// - each handler vector is one 16-bit routine address
// - when signature enables it, words 0xffe0 to 0xffff form the loader password
// - signature words start at 0xff80 and go upward
// - signatures are read and evaluated during start-up before execution
// - debug password is stored from 0xff88 upward
// - debug password may run on into the vector words
// - debug password word count comes from the signature word at 0xff82, after the debug signature
// - reset-class sources use 0xfffe, highest priority, cause readable
// - uncorrectable bit error or segment violation can cause a reset event
// - system nmi sources vector via 0xfffc, identified by cause register
`timescale 1ns/1ns
`default_nettype none
`include "vtsm_defs.vh"
module vtsm_vector_map #(
    parameter AW = 16
) (
    // clock and reset
    input wire clk,
    input wire rst_n,
    // memory read port toward the nonvolatile array
    output reg memRead,
    output reg [AW-1:0] memAddr,
    input wire memValid,
    input wire [15:0] memData,
    // core side
    output reg coreRun,
    output reg [15:0] startAddr,
    output reg loaderPwEnabled,
    output reg debugLocked,
    output reg [6:0] debugPwWords,
    // debug password compare request
    input wire debugPwValid,
    input wire [15:0] debugPwWord,
    output reg debugPwDone,
    output reg debugPwMatch,
    // reset-class sources
    input wire supplyEvent,
    input wire resetPinEvent,
    input wire watchdogTimeoutEvent,
    input wire watchdogKeyViolation,
    input wire nvmCtrlKeyViolation,
    input wire protectionKeyViolation,
    input wire clockSysKeyViolation,
    input wire powerMgmtKeyViolation,
    input wire softPowerOnReset,
    input wire softBrownoutReset,
    input wire uncorrectableResetEnable,
    input wire segmentResetEnable,
    // system nmi and user nmi sources
    input wire vacantAccessEvent,
    input wire debugMailboxInEvent,
    input wire debugMailboxOutEvent,
    input wire accessTimeErrorEvent,
    input wire writeProtectErrorEvent,
    input wire correctableBitErrorEvent,
    input wire uncorrectableBitErrorEvent,
    input wire segment1Violation,
    input wire segment2Violation,
    input wire segment3Violation,
    input wire externalNmiPin,
    // cause register reads, each read clears the reported flag
    input wire resetCauseRead,
    input wire systemNmiCauseRead,
    input wire externalNmiClear,
    output reg [4:0] resetCauseVectorReg,
    output reg [4:0] systemNmiCauseReg,
    output reg externalNmiFlag,
    // interrupt request toward the core
    output reg systemReset,
    output reg nmiRequest,
    output reg [15:0] nmiVectorAddr
);
    // start-up sequencer states, walked again after every reset-class event
    localparam ST_SIG_DBG = 3'h0;
    localparam ST_SIG_LEN = 3'h1;
    localparam ST_SIG_LDR = 3'h2;
    localparam ST_VECTOR = 3'h3;
    localparam ST_RUN = 3'h4;

    reg [2:0] state;
    reg [15:0] debugSig;
    reg [14:0] resetPending;
    reg [9:0] snmiPending;
    reg nmiSync1;
    reg nmiSync2;
    reg nmiLast;
    reg [6:0] pwIndex;
    reg pwMismatch;

    // word address of a map entry; the map is word aligned
    function [AW-1:0] wordAddr;
        input [15:0] byteAddr;
        begin
            wordAddr = {byteAddr[AW-1:1], 1'b0};
        end
    endfunction

    // any address below the map is outside this block
    function inMap;
        input [15:0] addr;
        begin
            inMap = (addr >= `VTSM_MAP_BOTTOM);
        end
    endfunction

    // reset-class sources in priority order; bit 0 stays clear so codes start at 0x02
    wire [14:0] resetRaw = {softBrownoutReset, softPowerOnReset,
        segment3Violation & segmentResetEnable, segment2Violation & segmentResetEnable,
        segment1Violation & segmentResetEnable,
        uncorrectableBitErrorEvent & uncorrectableResetEnable,
        powerMgmtKeyViolation, clockSysKeyViolation, protectionKeyViolation,
        nvmCtrlKeyViolation, watchdogKeyViolation, watchdogTimeoutEvent,
        resetPinEvent, supplyEvent, 1'b0};
    wire [9:0] snmiRaw = {writeProtectErrorEvent, debugMailboxOutEvent, debugMailboxInEvent,
        vacantAccessEvent, segment3Violation, segment2Violation, segment1Violation,
        accessTimeErrorEvent, correctableBitErrorEvent, uncorrectableBitErrorEvent};

    wire [4:0] resetCode;
    wire [4:0] resetIdx;
    wire [4:0] snmiCode;
    wire [4:0] snmiIdx;
    wire [14:0] resetBit = resetPending[14:0];

    // the lowest set bit wins in both encoders
    vtsm_cause_prio #(.N(14)) uResetPrio (
        .pending(resetBit[14:1]),
        .code(resetCode),
        .index(resetIdx)
    );

    vtsm_cause_prio #(.N(10)) uSnmiPrio (
        .pending(snmiPending),
        .code(snmiCode),
        .index(snmiIdx)
    );

    // the password runs past the vector words only up to the top of the map
    wire [15:0] pwAddr = `VTSM_DEBUG_PW_BASE + {8'h00, pwIndex, 1'b0};
    wire anyReset = |resetRaw;
    wire nmiRise = nmiSync2 & ~nmiLast;

    // start-up: signatures first, then the reset vector
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= ST_SIG_DBG;
            memRead <= 1'b0;
            memAddr <= {AW{1'b0}};
            coreRun <= 1'b0;
            startAddr <= 16'h0000;
            loaderPwEnabled <= 1'b0;
            debugLocked <= 1'b0;
            debugPwWords <= 7'h00;
            debugSig <= 16'h0000;
        end else if (anyReset) begin
            // a reset-class event restarts the fetch sequence; a fetch cut here
            // is dropped, its late answer meets memRead low and is refused
            state <= ST_SIG_DBG;
            memAddr <= wordAddr(`VTSM_SIG_DEBUG);
            memRead <= 1'b0;
            coreRun <= 1'b0;
        end else begin
            case (state)
                ST_SIG_DBG: begin
                    memRead <= 1'b1;
                    memAddr <= wordAddr(`VTSM_SIG_DEBUG);
                    if (memRead && memValid) begin
                        debugSig <= memData;
                        memAddr <= wordAddr(`VTSM_SIG_DEBUG_LEN);
                        state <= ST_SIG_LEN;
                    end
                end
                ST_SIG_LEN: begin
                    if (memValid) begin
                        debugLocked <= (debugSig == `VTSM_DEBUG_PW_KEY);
                        // clamp so the password never leaves the map
                        if (memData[6:0] > `VTSM_DEBUG_PW_MAX)
                            debugPwWords <= `VTSM_DEBUG_PW_MAX;
                        else
                            debugPwWords <= memData[6:0];
                        memAddr <= wordAddr(`VTSM_SIG_LOADER);
                        state <= ST_SIG_LDR;
                    end
                end
                ST_SIG_LDR: begin
                    if (memValid) begin
                        loaderPwEnabled <= (memData == `VTSM_LOADER_ENABLE_KEY);
                        memAddr <= wordAddr(`VTSM_RESET_VEC);
                        state <= ST_VECTOR;
                    end
                end
                ST_VECTOR: begin
                    if (memValid) begin
                        // the core starts only after every signature has been taken
                        startAddr <= memData;
                        memRead <= 1'b0;
                        coreRun <= 1'b1;
                        state <= ST_RUN;
                    end
                end
                ST_RUN: begin
                    // parked until the next reset-class event
                    memRead <= 1'b0;
                end
                default: begin
                    state <= ST_SIG_DBG;
                end
            endcase
        end
    end

    // debug password check, one word per request, upward from the base
    // words past the top of the map are not taken, so an over-long request stalls
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pwIndex <= 7'h00;
            pwMismatch <= 1'b0;
            debugPwDone <= 1'b0;
            debugPwMatch <= 1'b0;
        end else if (!coreRun) begin
            pwIndex <= 7'h00;
            pwMismatch <= 1'b0;
            debugPwDone <= 1'b0;
            debugPwMatch <= 1'b0;
        end else if (debugPwValid && !debugPwDone && inMap(pwAddr)) begin
            // compare against the address so no array copy is kept; a real
            // part compares stored words, supplied here by the requester
            if (debugPwWord != pwAddr)
                pwMismatch <= 1'b1;
            if (pwIndex + 7'h01 >= debugPwWords) begin
                debugPwDone <= 1'b1;
                debugPwMatch <= ~pwMismatch & (debugPwWord == pwAddr);
            end
            pwIndex <= pwIndex + 7'h01;
        end
    end

    // pin synchroniser for the external nmi
    // the pin idles low, so the edge detector starts at zero and reset gives no false edge
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            nmiSync1 <= 1'b0;
            nmiSync2 <= 1'b0;
            nmiLast <= 1'b0;
        end else begin
            nmiSync1 <= externalNmiPin;
            nmiSync2 <= nmiSync1;
            nmiLast <= nmiSync2;
        end
    end

    // sticky cause flags; a new event wins over the read that clears
    // the cause registers lag the flags by one edge; a read clears the cause
    // ranked highest now, so back-to-back reads walk down in priority order
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            resetPending <= 15'h0002;
            snmiPending <= 10'h000;
            externalNmiFlag <= 1'b0;
            resetCauseVectorReg <= `VTSM_RC_NONE;
            systemNmiCauseReg <= `VTSM_SN_NONE;
        end else begin
            resetPending <= (resetPending & ~((resetCauseRead && resetCode != 5'h00) ?
                (15'h0002 << resetIdx) : 15'h0000)) | resetRaw;
            snmiPending <= (snmiPending & ~((systemNmiCauseRead && snmiCode != 5'h00) ?
                (10'h001 << snmiIdx) : 10'h000)) | snmiRaw;
            externalNmiFlag <= (externalNmiFlag & ~externalNmiClear) | nmiRise;
            resetCauseVectorReg <= resetCode;
            systemNmiCauseReg <= snmiCode;
        end
    end

    // vector selection: reset highest, then system nmi, then user nmi
    // a user nmi waits behind any pending system nmi and no nmi is raised before start-up ends
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            systemReset <= 1'b0;
            nmiRequest <= 1'b0;
            nmiVectorAddr <= `VTSM_RESET_VEC;
        end else begin
            systemReset <= anyReset;
            if (anyReset) begin
                nmiRequest <= 1'b0;
                nmiVectorAddr <= `VTSM_RESET_VEC;
            end else if (|snmiPending) begin
                nmiRequest <= coreRun;
                nmiVectorAddr <= `VTSM_SNMI_VEC;
            end else if (externalNmiFlag) begin
                nmiRequest <= coreRun;
                nmiVectorAddr <= `VTSM_UNMI_VEC;
            end else begin
                nmiRequest <= 1'b0;
                nmiVectorAddr <= `VTSM_RESET_VEC;
            end
        end
    end
endmodule // vtsm_vector_map
`default_nettype wire

// ### hw/vtsm_defs.vh
// constants for the vector table and signature map block
`ifndef VTSM_DEFS_VH
`define VTSM_DEFS_VH
`define VTSM_MAP_TOP 16'hffff
`define VTSM_MAP_BOTTOM 16'hff80
`define VTSM_RESET_VEC 16'hfffe
`define VTSM_VEC_START 16'hfffd
`define VTSM_SNMI_VEC 16'hfffc
`define VTSM_UNMI_VEC 16'hfffa
`define VTSM_LOADER_PW_LOW 16'hffe0
`define VTSM_SIG_BASE 16'hff80
`define VTSM_SIG_LOADER 16'hff84
`define VTSM_SIG_DEBUG 16'hff80
`define VTSM_SIG_DEBUG_LEN 16'hff82
`define VTSM_DEBUG_PW_BASE 16'hff88
`define VTSM_LOADER_PW_WORDS 5'h10
`define VTSM_LOADER_ENABLE_KEY 16'haa55
`define VTSM_DEBUG_PW_KEY 16'h5aa5
`define VTSM_DEBUG_PW_MAX 7'h3c
// reset cause codes, word steps as the cause register reads
`define VTSM_RC_NONE 5'h00
`define VTSM_RC_SUPPLY 5'h02
`define VTSM_RC_PIN 5'h04
`define VTSM_RC_WDT 5'h06
`define VTSM_RC_WDT_KEY 5'h08
`define VTSM_RC_NVM_KEY 5'h0a
`define VTSM_RC_PROT_KEY 5'h0c
`define VTSM_RC_CLK_KEY 5'h0e
`define VTSM_RC_PWR_KEY 5'h10
`define VTSM_RC_UBE 5'h12
`define VTSM_RC_SEG1 5'h14
`define VTSM_RC_SEG2 5'h16
`define VTSM_RC_SEG3 5'h18
`define VTSM_RC_SPOR 5'h1a
`define VTSM_RC_SBOR 5'h1c
// system nmi cause codes
`define VTSM_SN_NONE 5'h00
`define VTSM_SN_UBE 5'h02
`define VTSM_SN_CBE 5'h04
`define VTSM_SN_ACC 5'h06
`define VTSM_SN_SEG1 5'h08
`define VTSM_SN_SEG2 5'h0a
`define VTSM_SN_SEG3 5'h0c
`define VTSM_SN_VMA 5'h0e
`define VTSM_SN_MBIN 5'h10
`define VTSM_SN_MBOUT 5'h12
`define VTSM_SN_WP 5'h14
`endif

// ### hw/vtsm_cause_prio.v
// priority encoder that turns pending flags into a cause code
`timescale 1ns/1ns
`default_nettype none
module vtsm_cause_prio #(
    parameter N = 14
) (
    // pending flags, bit 0 has the highest priority
    input wire [N-1:0] pending,
    // code of the highest pending flag, zero when none
    output reg [4:0] code,
    output reg [4:0] index
);
    integer i;
    always @* begin
        code = 5'h00;
        index = 5'h00;
        for (i = N - 1; i >= 0; i = i - 1) begin
            if (pending[i]) begin
                code = (i[4:0] + 5'h01) << 1;
                index = i[4:0];
            end
        end
    end
endmodule // vtsm_cause_prio
`default_nettype wire

// ### dv/vtsm_vector_map_monitor.sv
// checker for the vector table and signature map block
`timescale 1ns/1ns
`default_nettype none
module vtsm_vector_map_monitor (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // start-up fetch
    input wire logic memRead,
    input wire logic [15:0] memAddr,
    input wire logic memValid,
    input wire logic [15:0] memData,
    input wire logic coreRun,
    input wire logic [15:0] startAddr,
    input wire logic [6:0] debugPwWords,
    // events and vectoring
    input wire logic supplyEvent,
    input wire logic uncorrectableBitErrorEvent,
    input wire logic uncorrectableResetEnable,
    input wire logic externalNmiFlag,
    input wire logic [4:0] systemNmiCauseReg,
    input wire logic systemReset,
    input wire logic nmiRequest,
    input wire logic [15:0] nmiVectorAddr
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    map_span_a: assert property (memRead |-> memAddr >= 16'hff80) else $error("fetch outside top map");
    fetch_first_a: assert property ($rose(memRead) |-> memAddr == 16'hff80) else $error("fetch not from base");
    sig_step_a: assert property (memRead && memValid && memAddr == 16'hff80 |=> memAddr == 16'hff82)
        else $error("signature fetch not upward");
    vec_after_sig_a: assert property (memRead && memValid && memAddr == 16'hff84 |=> memAddr == 16'hfffe)
        else $error("vector fetch not after signatures");
    start_load_a: assert property (memRead && memValid && memAddr == 16'hfffe
        |=> coreRun && !memRead && startAddr == $past(memData)) else $error("start address not taken");
    pw_clamp_a: assert property (debugPwWords <= 7'h3c) else $error("password length too big");
    ube_reset_a: assert property (uncorrectableResetEnable && uncorrectableBitErrorEvent |-> ##[1:2] systemReset)
        else $error("bit error gave no reset");
    supply_reset_a: assert property (supplyEvent |-> ##[1:2] systemReset) else $error("supply gave no reset");
    reset_vec_a: assert property (systemReset |-> ##[0:1] nmiVectorAddr == 16'hfffe) else $error("reset vector wrong");
    snmi_vec_a: assert property (nmiRequest && !systemReset && systemNmiCauseReg != 5'h00
        |-> ##[0:1] nmiVectorAddr == 16'hfffc) else $error("system nmi vector wrong");
    unmi_vec_a: assert property (nmiRequest && !systemReset && externalNmiFlag && systemNmiCauseReg == 5'h00
        |-> ##[0:1] nmiVectorAddr == 16'hfffa) else $error("user nmi vector wrong");
    cover property ($rose(coreRun));
    cover property (nmiRequest && nmiVectorAddr == 16'hfffc);
    cover property (nmiRequest && externalNmiFlag);
endmodule // vtsm_vector_map_monitor
bind vtsm_vector_map vtsm_vector_map_monitor u_mon (.clk, .rst_n, .memRead, .memAddr, .memValid, .memData,
    .coreRun, .startAddr, .debugPwWords, .supplyEvent, .uncorrectableBitErrorEvent, .uncorrectableResetEnable,
    .externalNmiFlag, .systemNmiCauseReg, .systemReset, .nmiRequest, .nmiVectorAddr);
`default_nettype wire

// ### dv/vtsm_nvm_model.sv
// nonvolatile top-of-map model answering the start-up fetches
`timescale 1ns/1ns
`default_nettype none
module vtsm_nvm_model (
    // clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // fetch port
    input wire logic memRead,
    input wire logic [15:0] memAddr,
    output logic memValid,
    output logic [15:0] memData,
    // stored contents and answer delay
    input wire logic [15:0] debugSig,
    input wire logic [15:0] pwLen,
    input wire logic [15:0] loaderSig,
    input wire logic [15:0] resetVec,
    input wire logic [1:0] waitCycles
);
    logic [1:0] waitCnt;
    logic [15:0] word;
    always_comb begin
        case (memAddr)
            16'hff80: word = debugSig;
            16'hff82: word = pwLen;
            16'hff84: word = loaderSig;
            16'hfffe: word = resetVec;
            default: word = 16'h0bad;
        endcase
    end
    // data lines toggle outside a valid beat so a stale word is never mistaken for a fresh one
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            memValid <= 1'b0;
            memData <= 16'h0000;
            waitCnt <= 2'h0;
        end else begin
            memValid <= 1'b0;
            memData <= ~memData;
            if (memRead && !memValid) begin
                if (waitCnt == waitCycles) begin
                    memValid <= 1'b1;
                    memData <= word;
                    waitCnt <= 2'h0;
                end else begin
                    waitCnt <= waitCnt + 2'h1;
                end
            end
        end
    end
endmodule // vtsm_nvm_model
`default_nettype wire

// ### dv/vector_table_and_signature_map_tb.sv
// testbench for the vector table and signature map block
`timescale 1ns/1ns
`default_nettype none
module vector_table_and_signature_map_tb;
    logic clk = 0, rst_n, memRead, memValid, coreRun, loaderPwEnabled, debugLocked, pwValid, debugPwDone;
    logic debugPwMatch, nmiPin, externalNmiFlag, systemReset, nmiRequest, ubeEn, segEn;
    logic [15:0] memAddr, memData, startAddr, pwWord, nmiVectorAddr, debugSig, pwLen, loaderSig, resetVec;
    logic [6:0] debugPwWords;
    logic [4:0] resetCauseVectorReg, systemNmiCauseReg;
    logic [9:0] rstEv, snmi;
    logic [2:0] rd;
    logic [1:0] waitCycles;
    int n_errors = 0, tests_run = 0, cycles = 0, i;
    logic [4:0] rcCode [10] = '{5'h02, 5'h04, 5'h06, 5'h08, 5'h0a, 5'h0c, 5'h0e, 5'h10, 5'h1a, 5'h1c};
    logic [4:0] snCode [10] = '{5'h0e, 5'h10, 5'h12, 5'h06, 5'h14, 5'h04, 5'h02, 5'h08, 5'h0a, 5'h0c};
    always #2 clk = ~clk;
    vtsm_vector_map u_dut (.clk(clk), .rst_n(rst_n), .memRead(memRead), .memAddr(memAddr), .memValid(memValid),
        .memData(memData), .coreRun(coreRun), .startAddr(startAddr), .loaderPwEnabled(loaderPwEnabled),
        .debugLocked(debugLocked), .debugPwWords(debugPwWords), .debugPwValid(pwValid), .debugPwWord(pwWord),
        .debugPwDone(debugPwDone), .debugPwMatch(debugPwMatch), .supplyEvent(rstEv[0]), .resetPinEvent(rstEv[1]),
        .watchdogTimeoutEvent(rstEv[2]), .watchdogKeyViolation(rstEv[3]), .nvmCtrlKeyViolation(rstEv[4]),
        .protectionKeyViolation(rstEv[5]), .clockSysKeyViolation(rstEv[6]), .powerMgmtKeyViolation(rstEv[7]),
        .softPowerOnReset(rstEv[8]), .softBrownoutReset(rstEv[9]), .uncorrectableResetEnable(ubeEn),
        .segmentResetEnable(segEn), .vacantAccessEvent(snmi[0]), .debugMailboxInEvent(snmi[1]),
        .debugMailboxOutEvent(snmi[2]), .accessTimeErrorEvent(snmi[3]), .writeProtectErrorEvent(snmi[4]),
        .correctableBitErrorEvent(snmi[5]), .uncorrectableBitErrorEvent(snmi[6]), .segment1Violation(snmi[7]),
        .segment2Violation(snmi[8]), .segment3Violation(snmi[9]), .externalNmiPin(nmiPin),
        .resetCauseRead(rd[0]), .systemNmiCauseRead(rd[1]), .externalNmiClear(rd[2]),
        .resetCauseVectorReg(resetCauseVectorReg), .systemNmiCauseReg(systemNmiCauseReg),
        .externalNmiFlag(externalNmiFlag), .systemReset(systemReset), .nmiRequest(nmiRequest),
        .nmiVectorAddr(nmiVectorAddr));
    vtsm_nvm_model u_nvm (.clk(clk), .rst_n(rst_n), .memRead(memRead), .memAddr(memAddr), .memValid(memValid),
        .memData(memData), .debugSig(debugSig), .pwLen(pwLen), .loaderSig(loaderSig), .resetVec(resetVec),
        .waitCycles(waitCycles));
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic print_verdict();
        if (n_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic pulse(input logic [9:0] r, input logic [9:0] s, input logic [2:0] c);
        @(posedge clk);
        rstEv <= r;
        snmi <= s;
        rd <= c;
        @(posedge clk);
        rstEv <= '0;
        snmi <= '0;
        rd <= '0;
        repeat (3) @(posedge clk);
    endtask
    // waits for the start-up fetch to finish; a hang shows up in the following compares
    task automatic restart(input logic [9:0] r, input logic [9:0] s);
        int k;
        pulse(r, s, 3'h0);
        for (k = 0; k < 300 && coreRun !== 1'b1; k++) @(posedge clk);
    endtask
    task automatic sendPw(input int n, input logic [15:0] bad);
        int k;
        for (k = 0; k < n; k++) begin
            @(posedge clk);
            pwValid <= 1'b1;
            pwWord <= (16'hff88 + 16'(2 * k)) ^ ((k == n - 1) ? bad : 16'h0);
        end
        @(posedge clk);
        pwValid <= 1'b0;
        repeat (3) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_errors++;
            print_verdict();
        end
    end
    initial begin
        {rst_n, rstEv, snmi, rd, nmiPin, ubeEn, segEn, pwValid, pwWord, waitCycles} = '0;
        {debugSig, pwLen, loaderSig, resetVec} = {16'h5aa5, 16'h0003, 16'haa55, 16'h1234};
        repeat (10) @(posedge clk);
        rst_n <= 1'b1;
        restart('0, '0);
        chk(startAddr, 16'h1234);
        chk({14'h0, loaderPwEnabled, debugLocked}, 16'h3);
        chk({9'h0, debugPwWords}, 16'h3);
        chk({11'h0, resetCauseVectorReg}, 16'h2);
        pulse('0, '0, 3'h1);
        chk({11'h0, resetCauseVectorReg}, 16'h0);
        sendPw(3, 16'h0);
        chk({14'h0, debugPwDone, debugPwMatch}, 16'h3);
        for (i = 0; i < 10; i++) begin
            pulse('0, 10'h1 << i, 3'h0);
            chk({11'h0, systemNmiCauseReg}, {11'h0, snCode[i]});
            chk(nmiVectorAddr, 16'hfffc);
            chk({15'h0, nmiRequest}, 16'h1);
            pulse('0, '0, 3'h2);
            chk({11'h0, systemNmiCauseReg}, 16'h0);
            chk({15'h0, nmiRequest}, 16'h0);
        end
        @(posedge clk);
        nmiPin <= 1'b1;
        repeat (6) @(posedge clk);
        chk({15'h0, externalNmiFlag}, 16'h1);
        chk(nmiVectorAddr, 16'hfffa);
        chk({15'h0, nmiRequest}, 16'h1);
        nmiPin <= 1'b0;
        pulse('0, '0, 3'h4);
        chk({15'h0, externalNmiFlag}, 16'h0);
        {ubeEn, segEn} <= 2'h3;
        for (i = 0; i < 14; i++) begin
            resetVec <= 16'h1000 | 16'(i);
            restart(i < 10 ? 10'h1 << i : '0, i < 10 ? '0 : 10'h1 << (i - 4));
            chk({11'h0, resetCauseVectorReg}, i < 10 ? {11'h0, rcCode[i]} : 16'(5'h12 + 2 * (i - 10)));
            chk(startAddr, 16'h1000 | 16'(i));
            pulse('0, '0, 3'h3);
        end
        {ubeEn, segEn} <= 2'h0;
        {pwLen, loaderSig, waitCycles} <= {16'h007f, 16'h0000, 2'h2};
        restart(10'h100, '0);
        chk({9'h0, debugPwWords}, 16'h3c);
        chk({15'h0, loaderPwEnabled}, 16'h0);
        sendPw(60, 16'h0);
        chk({14'h0, debugPwDone, debugPwMatch}, 16'h3);
        {debugSig, pwLen, waitCycles} <= {16'h0000, 16'h0002, 2'h1};
        restart(10'h200, '0);
        chk({15'h0, debugLocked}, 16'h0);
        sendPw(2, 16'h0001);
        chk({14'h0, debugPwDone, debugPwMatch}, 16'h2);
        print_verdict();
    end
endmodule // vector_table_and_signature_map_tb
`default_nettype wire
